// [logic/evtmr_top.v]
// Event timer match and capture logic behind plain control ports.
// Assumes the central event counter arrives Gray-coded from another domain,
// and that the bus clock gating of the system keeps i_core_clk running during access.
`timescale 1ns/100ps
`include "evtmr_defs.vh"
module evtmr_top #(
  parameter CNT_W = `EVTMR_CNT_W
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [CNT_W-1:0] i_central_event_counter,
  input wire i_match_wr,
  input wire [CNT_W-1:0] i_match_wdata,
  input wire i_match_irq_en,
  input wire i_stat_clr,
  input wire [`EVTMR_STAT_W-1:0] i_stat_clr_mask,
  input wire i_capture,
  output reg [CNT_W-1:0] o_count_raw,
  output reg [CNT_W-1:0] o_match_raw,
  output reg [CNT_W-1:0] o_capture_raw,
  output wire [`EVTMR_STAT_W-1:0] o_status,
  output wire o_match_irq
);
  localparam STAT_W = `EVTMR_STAT_W;
  localparam MATCH_BIT = `EVTMR_STAT_MATCH_BIT;
  localparam [CNT_W-1:0] COUNT_RST = `EVTMR_COUNT_RST;
  localparam [CNT_W-1:0] MATCH_RST = `EVTMR_MATCH_RST;
  localparam [CNT_W-1:0] CAP_RST = `EVTMR_CAP_RST;

  wire [CNT_W-1:0] count_gray;
  wire match_hit;
  wire match_start;
  wire flag_clr;
  reg match_reached_flag;
  reg match_hit_q;
  reg [CNT_W-1:0] next_count_raw;
  reg [CNT_W-1:0] next_match_raw;
  reg [CNT_W-1:0] next_capture_raw;
  reg next_match_hit_q;
  reg next_match_reached_flag;

  // Gray code compares directly, so no decode is needed on the match path.
  function f_gray_equal;
    input [CNT_W-1:0] lhs;
    input [CNT_W-1:0] rhs;
    begin
      f_gray_equal = (lhs == rhs);
    end
  endfunction

  function f_mask_clears;
    input strobe;
    input [STAT_W-1:0] mask;
    begin
      f_mask_clears = strobe & mask[MATCH_BIT];
    end
  endfunction

  // Only the start of equality counts, so a count parked on the match value
  // does not set the flag again right after software has cleared it.
  function f_rising;
    input now_level;
    input old_level;
    begin
      f_rising = now_level & ~old_level;
    end
  endfunction

  function [STAT_W-1:0] f_status_word;
    input flag;
    begin
      f_status_word = {STAT_W{1'h0}};
      f_status_word[MATCH_BIT] = flag;
    end
  endfunction

  // A match arriving with a clear wins, so the event is not lost.
  function f_next_flag;
    input set_ev;
    input clr_ev;
    input current;
    begin
      case ({set_ev, clr_ev})
        2'h2: begin
          f_next_flag = 1'h1;
        end
        2'h3: begin
          f_next_flag = 1'h1;
        end
        2'h1: begin
          f_next_flag = 1'h0;
        end
        default: begin
          f_next_flag = current;
        end
      endcase
    end
  endfunction

  function [CNT_W-1:0] f_load;
    input load;
    input [CNT_W-1:0] value;
    input [CNT_W-1:0] current;
    begin
      if (load) begin
        f_load = value;
      end else begin
        f_load = current;
      end
    end
  endfunction

  evtmr_gray_sync #(
    .W(CNT_W)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_gray(i_central_event_counter),
    .o_gray(count_gray)
  );

  // The compare uses the synchronised count, one stage ahead of o_count_raw,
  // so the flag and the matching count appear on the same edge.
  assign match_hit = f_gray_equal(count_gray, o_match_raw);
  assign match_start = f_rising(match_hit, match_hit_q);
  assign flag_clr = f_mask_clears(i_stat_clr, i_stat_clr_mask);

  always @* begin
    next_count_raw = count_gray;
  end

  always @* begin
    next_match_raw = f_load(i_match_wr, i_match_wdata, o_match_raw);
  end

  always @* begin
    next_capture_raw = f_load(i_capture, count_gray, o_capture_raw);
  end

  always @* begin
    next_match_hit_q = match_hit;
  end

  always @* begin
    next_match_reached_flag = f_next_flag(match_start, flag_clr, match_reached_flag);
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_count_raw <= COUNT_RST;
    end else begin
      o_count_raw <= next_count_raw;
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_match_raw <= MATCH_RST;
    end else begin
      o_match_raw <= next_match_raw;
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_capture_raw <= CAP_RST;
    end else begin
      o_capture_raw <= next_capture_raw;
    end
  end

  // The edge detector idles low so that reset never leaves a false match start.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      match_hit_q <= 1'h0;
    end else begin
      match_hit_q <= next_match_hit_q;
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      match_reached_flag <= 1'h0;
    end else begin
      match_reached_flag <= next_match_reached_flag;
    end
  end

  assign o_status = f_status_word(match_reached_flag);
  assign o_match_irq = match_reached_flag & i_match_irq_en;
endmodule

// [logic/evtmr_defs.vh]
// Constants for the event timer match and capture block.
// Assumes a single core clock and a Gray-coded shared time base at the input.
`ifndef EVTMR_DEFS_VH
`define EVTMR_DEFS_VH
`define EVTMR_CNT_W 64
`define EVTMR_STAT_MATCH_BIT 0
`define EVTMR_MATCH_RST 64'hffffffffffffffff
`define EVTMR_COUNT_RST 64'h0000000000000000
`define EVTMR_CAP_RST 64'h0000000000000000
`define EVTMR_STAT_W 32
`endif

// [logic/evtmr_gray_sync.v]
// Synchroniser for a Gray-coded count arriving from another clock domain.
// Assumes the source changes at most one bit per step, so each bit is safe alone.
`timescale 1ns/100ps
module evtmr_gray_sync #(
  parameter W = 64
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [W-1:0] i_gray,
  output reg [W-1:0] o_gray
);
  reg [W-1:0] meta;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // A bit change is accepted only when the second and third stages agree.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      o_gray <= {W{1'b0}};
    end else begin
      meta <= i_gray;
      s2 <= meta;
      s3 <= s2;
      o_gray <= (s2 & ~(s2 ^ s3)) | (o_gray & (s2 ^ s3));
    end
  end
endmodule

// [verification/evtmr_sva.sv]
// Checker for the match, status and interrupt ports of the event timer top.
// Assumes inputs change away from the rising clock edge.
`timescale 1ns/100ps
module evtmr_sva (
  input wire i_core_clk, i_rst, i_match_wr, i_match_irq_en, i_stat_clr, o_match_irq,
  input wire i_capture,
  input wire [31:0] i_stat_clr_mask, o_status,
  input wire [63:0] o_count_raw, o_match_raw, o_capture_raw
);
  wire clr0 = i_stat_clr & i_stat_clr_mask[0];
  wire eq = o_count_raw == o_match_raw;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_match_hold: assert property (!i_match_wr |=> $stable(o_match_raw)) else $error("match");
  a_stat_only: assert property (o_status[31:1] == 0) else $error("status");
  a_irq_flag: assert property (o_match_irq == (o_status[0] & i_match_irq_en)) else $error("irq");
  a_flag_hold: assert property (o_status[0] && !clr0 |=> o_status[0]) else $error("hold");
  // A match that begins at the clear edge wins, so only a calm count is judged.
  a_flag_clr: assert property (clr0 && !eq ##1 $stable(o_count_raw) |-> !o_status[0])
    else $error("clear");
  a_flag_set: assert property ($rose(eq) |-> ##[0:1] o_status[0]) else $error("set");
  a_set_cause: assert property ($rose(o_status[0]) |-> eq) else $error("cause");
  a_irq_off: assert property (!i_match_irq_en |-> !o_match_irq) else $error("mask");
  a_cap_hold: assert property (!i_capture |=> $stable(o_capture_raw))
    else $error("capture hold");
  a_cap_load: assert property (i_capture |=> o_capture_raw == o_count_raw)
    else $error("capture load");
  cover property (o_match_irq);
  cover property (clr0 && o_status[0]);
  cover property ($rose(o_status[0]));
endmodule
bind evtmr_top evtmr_sva i_evtmr_sva (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_match_wr(i_match_wr),
  .i_match_irq_en(i_match_irq_en),
  .i_stat_clr(i_stat_clr),
  .o_match_irq(o_match_irq),
  .i_capture(i_capture),
  .i_stat_clr_mask(i_stat_clr_mask),
  .o_status(o_status),
  .o_count_raw(o_count_raw),
  .o_match_raw(o_match_raw),
  .o_capture_raw(o_capture_raw)
);

// [verification/tb_evtmr_top.sv]
// Bench for the event timer top; t_match, t_clear and t_reset each drive and judge one group of cases.
// Assumes a 20 MHz core clock; inputs move on the falling edge.
`timescale 1ns/100ps
`include "evtmr_defs.vh"
module tb_evtmr_top;
  reg i_core_clk = 0, i_rst = 1, i_match_wr = 0, i_match_irq_en = 0, i_stat_clr = 0;
  reg i_capture = 0;
  reg [63:0] i_central_event_counter = 0, i_match_wdata = 7;
  reg [31:0] i_stat_clr_mask = 0;
  wire [63:0] o_count_raw, o_match_raw, o_capture_raw;
  wire [31:0] o_status;
  wire o_match_irq;
  integer miscompares = 0, checks_done = 0, cyc = 0, n;
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (++cyc == 500) end_of_test;
  evtmr_top i_evtmr_top (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_central_event_counter(i_central_event_counter),
    .i_match_wr(i_match_wr),
    .i_match_wdata(i_match_wdata),
    .i_match_irq_en(i_match_irq_en),
    .i_stat_clr(i_stat_clr),
    .i_stat_clr_mask(i_stat_clr_mask),
    .i_capture(i_capture),
    .o_count_raw(o_count_raw),
    .o_match_raw(o_match_raw),
    .o_capture_raw(o_capture_raw),
    .o_status(o_status),
    .o_match_irq(o_match_irq)
  );
  task ck(input string what, input [63:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    if (cyc >= 500) begin
      miscompares++;
      $display("mismatch timeout expected %0d seen %0d", 500, cyc);
    end
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_match;
    @(negedge i_core_clk) {i_match_wr, i_match_irq_en} = 2'b11;
    @(negedge i_core_clk) {i_match_wr, i_match_wdata} = 65'h0;
    ck("match", 64'h7, o_match_raw);
    // Each Gray step is held long enough for the synchroniser to agree.
    for (n = 1; n < 6; n++) begin
      @(negedge i_core_clk) i_central_event_counter = n ^ (n >> 1);
      repeat (8) @(negedge i_core_clk);
      ck("count", n ^ (n >> 1), o_count_raw);
      ck("flag", (n == 5) * 3, {o_status, o_match_irq});
    end
  endtask
  task t_clear;
    @(negedge i_core_clk) {i_stat_clr, i_stat_clr_mask, i_match_irq_en} = 34'h3fffffffc;
    @(negedge i_core_clk) {i_stat_clr, i_match_wr, i_capture} = 3'b011;
    ck("kept", 64'h2, {o_status, o_match_irq});
    @(negedge i_core_clk) {i_stat_clr, i_match_wr, i_capture, i_stat_clr_mask} = 35'h400000001;
    ck("capture", 64'h7, o_capture_raw);
    ck("rewrite", 64'h0, o_match_raw);
    @(negedge i_core_clk) i_stat_clr = 0;
    ck("cleared", 64'h0, {o_status, o_match_irq});
  endtask
  // A reset in mid-run must restore every register and resynchronise the count.
  task t_reset;
    @(negedge i_core_clk) i_rst = 1;
    @(negedge i_core_clk) ck("rst match", `EVTMR_MATCH_RST, o_match_raw);
    ck("rst capture", `EVTMR_CAP_RST, o_capture_raw);
    ck("rst count", `EVTMR_COUNT_RST, o_count_raw);
    ck("rst status", 64'h0, {o_status, o_match_irq});
    i_rst = 0;
    repeat (8) @(negedge i_core_clk);
    ck("resync count", 64'h7, o_count_raw);
    ck("resync match", `EVTMR_MATCH_RST, o_match_raw);
    ck("resync flag", 64'h0, {o_status, o_match_irq});
  endtask
  initial begin
    repeat (10) @(negedge i_core_clk);
    i_rst = 0;
    t_match;
    t_clear;
    t_reset;
    end_of_test;
  end
endmodule
